// *** verif/tb_vout_target_control.sv ***
// Self-checking bench for the output-voltage target block.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_vout_target_control;
    import vtc_pkg::*;
    logic core_clk, reset_n, cmd_wr, cmd_rd, cmd_rvalid;
    logic conversion_enabled, restore_user_all, default_source_select;
    logic reset_pin_mode, power_good_or_reset_pin, fault_shutdown;
    logic fault_restore_default_bit, reference_settled;
    logic voltage_limit_warning, invalid_data, host_alert;
    logic [1:0] loop_scale_sel;
    logic [7:0] cmd_code, nv_offset, nv_format, nv_offset_backup;
    logic [15:0] cmd_wdata, cmd_rdata, transition_rate;
    logic [15:0] voltage_select_pin, nv_target;
    logic [23:0] limit_max, limit_min, reference_level;
    int miscompares = 0;
    int n_checks = 0;
    vtc_target dut (
        .core_clk, .reset_n, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata,
        .cmd_rdata, .cmd_rvalid, .limit_max, .limit_min, .loop_scale_sel,
        .transition_rate, .conversion_enabled, .restore_user_all,
        .default_source_select, .voltage_select_pin, .nv_target,
        .nv_offset, .nv_format, .reset_pin_mode, .power_good_or_reset_pin,
        .fault_restore_default_bit, .fault_shutdown, .reference_level,
        .reference_settled, .nv_offset_backup, .voltage_limit_warning,
        .invalid_data, .host_alert
    );
    vtc_host_model host (
        .core_clk, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .cmd_rdata,
        .cmd_rvalid
    );
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic chk(input string w, input logic [23:0] e,
            input logic [23:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic flg(input string w, input logic e, input logic g);
        chk(w, {23'h0, e}, {23'h0, g});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Format reads carry only the low byte.
    task automatic rdc(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] d;
        host.rd(c, d);
        if (c == 8'h20) d = {8'h00, d[7:0]};
        chk("readback", {8'h00, e}, {8'h00, d});
        cyc(1);
    endtask
    // Waits out the slew, at one step of transition_rate per 250 cycles.
    task automatic settle(input logic [23:0] e);
        int n;
        n = 0;
        cyc(4);
        while (reference_settled !== 1'b1 && n < 4000) begin
            cyc(1);
            n++;
        end
        chk("reference_level", e, reference_level);
    endtask
    task automatic ev(input logic fault);
        if (fault) fault_shutdown = 1'b1;
        else restore_user_all = 1'b1;
        cyc(1);
        fault_shutdown = 1'b0;
        restore_user_all = 1'b0;
        cyc(2);
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    task automatic t_boot();
        rdc(8'h21, 16'h0800);
        rdc(8'h20, 16'h0014);
        rdc(8'h22, 16'h0000);
        settle(24'h000800);
        host.wr(8'h21, 16'h0A00);
        rdc(8'h21, 16'h0A00);
        settle(24'h000A00);
        $display("test boot done");
    endtask
    task automatic t_format();
        logic [7:0] bad [3] = '{8'h34, 8'h1D, 8'h13};
        conversion_enabled = 1'b1;
        host.wr(8'h20, 16'h001C);
        cyc(1);
        flg("invalid_data", 1'b1, invalid_data);
        rdc(8'h20, 16'h0014);
        rdc(8'h22, 16'h0000);
        flg("invalid_data", 1'b0, invalid_data);
        conversion_enabled = 1'b0;
        foreach (bad[i]) begin
            host.wr(8'h20, {8'h00, bad[i]});
            cyc(1);
            flg("invalid_data", 1'b1, invalid_data);
            rdc(8'h22, 16'h0000);
        end
        rdc(8'h20, 16'h0014);
        host.wr(8'h20, 16'h001C);
        flg("invalid_data", 1'b0, invalid_data);
        rdc(8'h21, 16'h000A);
        host.wr(8'h21, 16'h000B);
        host.wr(8'h20, 16'h0094);
        rdc(8'h20, 16'h0094);
        rdc(8'h21, 16'h0B00);
        settle(24'h000B00);
        host.wr(8'h20, 16'h0014);
        $display("test format done");
    endtask
    task automatic t_limits();
        logic [15:0] d;
        host.wr(8'h21, 16'h1200);
        cyc(2);
        flg("warning", 1'b1, voltage_limit_warning);
        flg("host_alert", 1'b1, host_alert);
        settle(24'h001000);
        host.rd(8'h21, d);
        cyc(1);
        flg("warning", 1'b0, voltage_limit_warning);
        host.wr(8'h21, 16'h0A00);
        host.wr(8'h22, 16'hFF00);
        settle(24'h000900);
        chk("backup", 24'h000080, {16'h0, nv_offset_backup});
        host.wr(8'h22, 16'h0010);
        settle(24'h000A10);
        chk("backup", 24'h000010, {16'h0, nv_offset_backup});
        host.wr(8'h22, 16'h8000);
        cyc(1);
        flg("invalid_data", 1'b1, invalid_data);
        rdc(8'h22, 16'h0010);
        host.wr(8'h22, 16'h0000);
        limit_min = 24'h000500;
        host.wr(8'h21, 16'h0400);
        settle(24'h000500);
        flg("warning", 1'b1, voltage_limit_warning);
        limit_min = 24'h000000;
        host.rd(8'h21, d);
        loop_scale_sel = 2'h0;
        host.wr(8'h21, 16'h0C00);
        settle(24'h000B33);
        flg("warning", 1'b0, voltage_limit_warning);
        loop_scale_sel = 2'h3;
        $display("test limits done");
    endtask
    task automatic t_events();
        reset_pin_mode = 1'b1;
        power_good_or_reset_pin = 1'b0;
        cyc(2);
        power_good_or_reset_pin = 1'b1;
        cyc(2);
        rdc(8'h21, 16'h0800);
        host.wr(8'h21, 16'h0A00);
        ev(1'b1);
        rdc(8'h21, 16'h0A00);
        fault_restore_default_bit = 1'b1;
        ev(1'b1);
        rdc(8'h21, 16'h0800);
        default_source_select = 1'b1;
        ev(1'b0);
        rdc(8'h21, 16'h0600);
        settle(24'h000600);
        $display("test events done");
    endtask
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        reset_n = 1'b0;
        {conversion_enabled, restore_user_all, default_source_select} = '0;
        {reset_pin_mode, fault_restore_default_bit, fault_shutdown} = '0;
        power_good_or_reset_pin = 1'b1;
        loop_scale_sel = 2'h3;
        limit_max = 24'h001000;
        limit_min = 24'h000000;
        transition_rate = 16'h0400;
        voltage_select_pin = 16'h0600;
        nv_target = 16'h0800;
        nv_offset = 8'h00;
        nv_format = 8'h14;
        repeat (20) @(posedge core_clk);
        cyc(1);
        reset_n = 1'b1;
        cyc(2);
        t_boot();
        t_format();
        t_limits();
        t_events();
        give_verdict();
    end
    // The tests take some 3750 cycles; the limit of 30000 cycles allows eight times that.
    initial begin
        #120000;
        miscompares++;
        give_verdict();
    end
endmodule
bind vtc_target vtc_target_checker chk_i (
    .core_clk, .reset_n, .cmd_wr, .cmd_rd, .cmd_code, .cmd_rvalid,
    .conversion_enabled, .limit_max, .reference_level, .reference_settled,
    .voltage_limit_warning, .invalid_data, .host_alert
);
`default_nettype wire

// *** verif/vtc_host_model.sv ***
// Host side of the decoded command port: one-cycle write and read strobes.
// Assumes the bench calls its tasks from one process tied to core_clk.
`timescale 1ns/1ps
`default_nettype none
module vtc_host_model (
    // Clock.
    input wire logic core_clk,
    // Command port.
    output logic cmd_wr,
    output logic cmd_rd,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_rvalid
);
    initial begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // The format code is a byte transfer, the others whole words.
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge core_clk);
        cmd_code = c;
        cmd_wdata = (c == 8'h20) ? {8'h00, d[7:0]} : d;
        cmd_wr = 1'b1;
        @(negedge core_clk);
        cmd_wr = 1'b0;
        cmd_wdata = ~cmd_wdata;
        // A format write needs an idle cycle for its conversion.
        if (c == 8'h20) @(negedge core_clk);
    endtask
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        @(negedge core_clk);
        cmd_code = c;
        cmd_rd = 1'b1;
        @(negedge core_clk);
        cmd_rd = 1'b0;
        d = cmd_rvalid ? cmd_rdata : 16'hXXXX;
    endtask
endmodule
`default_nettype wire

// *** verif/vtc_target_checker.sv ***
// Assertions on the ports of the output-voltage target block.
// Assumes it is bound into vtc_target; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module vtc_target_checker
    import vtc_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Command port.
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_rvalid,
    // Limits and results.
    input wire logic conversion_enabled,
    input wire logic [23:0] limit_max,
    input wire logic [23:0] reference_level,
    input wire logic reference_settled,
    input wire logic voltage_limit_warning,
    input wire logic invalid_data,
    input wire logic host_alert
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    property p_read_answer;
        cmd_rd |=> cmd_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered in the next cycle");
    property p_answer_cause;
        cmd_rvalid |-> $past(cmd_rd);
    endproperty
    a_answer_cause: assert property (p_answer_cause)
        else $error("read answer without a read");
    property p_warn_hold;
        voltage_limit_warning && !(cmd_rd && cmd_code == 8'h21)
            |=> voltage_limit_warning;
    endproperty
    a_warn_hold: assert property (p_warn_hold)
        else $error("limit warning dropped without a target read");
    property p_inval_hold;
        invalid_data && !(cmd_rd && cmd_code == 8'h22) |=> invalid_data;
    endproperty
    a_inval_hold: assert property (p_inval_hold)
        else $error("invalid flag dropped without an offset read");
    property p_alert;
        $rose(voltage_limit_warning) || $rose(invalid_data)
            |-> ##[0:2] host_alert;
    endproperty
    a_alert: assert property (p_alert)
        else $error("host not alerted");
    property p_fmt_refused;
        cmd_wr && cmd_code == 8'h20 && conversion_enabled
            |-> ##[1:2] invalid_data;
    endproperty
    a_fmt_refused: assert property (p_fmt_refused)
        else $error("format write accepted while converting");
    property p_ref_pace;
        !$stable(reference_level) |=> $stable(reference_level)[*8];
    endproperty
    a_ref_pace: assert property (p_ref_pace)
        else $error("reference stepped faster than the step time");
    property p_ref_limit;
        reference_settled |-> reference_level <= limit_max;
    endproperty
    a_ref_limit: assert property (p_ref_limit)
        else $error("reference settled above the upper limit");
    c_warn: cover property ($rose(voltage_limit_warning));
    c_inval: cover property ($rose(invalid_data));
    c_settle: cover property ($rose(reference_settled));
endmodule
`default_nettype wire

// *** verilog/vtc_defines.svh ***
// Constants for the output-voltage target block: command codes, field
// positions, limits and timing counts. Definitions only.
`ifndef VTC_DEFINES_SVH
`define VTC_DEFINES_SVH

`define VTC_CMD_FORMAT 8'h20
`define VTC_CMD_TARGET 8'h21
`define VTC_CMD_OFFSET 8'h22
`define VTC_REL_BIT 7
`define VTC_MODE_HI 6
`define VTC_MODE_LO 5
`define VTC_EXP_HI 4
`define VTC_EXP_LO 0
`define VTC_MODE_LINEAR 2'h0
`define VTC_EXP_MIN (-12)
`define VTC_EXP_MAX (-4)
`define VTC_EXP_RESET 5'h14
`define VTC_NV_EXP (-12)
`define VTC_NV_TRIM_MAX 127
`define VTC_NV_TRIM_MIN (-128)
`define VTC_CLK_MHZ 250
`define VTC_STEP_TIME_NS 1000
`define VTC_STEP_CYCLES ((`VTC_STEP_TIME_NS * `VTC_CLK_MHZ) / 1000)
`define VTC_ACC_W 24

`endif

// *** verilog/vtc_pkg.sv ***
// Types shared by the output-voltage target block.
// Assumes vtc_defines.svh is compiled with it.
package vtc_pkg;
    typedef enum logic [1:0] {
        VTC_IDLE,
        VTC_CONVERT,
        VTC_SLEW
    } vtc_state_t;
    typedef logic [23:0] vtc_uv_t;
endpackage

// *** verilog/vtc_scale.sv ***
// Converts a linear mantissa with a given exponent to microvolt-like units
// scaled at exponent -12 (one LSB = 2^-12 V), and back. Pure logic.
`timescale 1ns/1ps
`default_nettype none
module vtc_scale
    import vtc_pkg::*;
(
    // Forward path: mantissa and exponent to fine units.
    input wire logic signed [16:0] mant_in,
    input wire logic [4:0] exp_in,
    output logic signed [23:0] fine_out,
    // Reverse path: fine units to mantissa at exponent.
    input wire logic signed [23:0] fine_in,
    output logic signed [16:0] mant_out
);
    logic [3:0] sh;
    // Exponents are -4..-12, so the shift toward -12 is 0..8.
    always_comb begin
        sh = 4'(5'sd12 + $signed(exp_in));
        fine_out = 24'(mant_in) <<< sh;
        mant_out = 17'(fine_in >>> sh);
    end
endmodule
`default_nettype wire

// *** verilog/vtc_slew.sv ***
// Moves the reference toward its target one step per time tick.
// Assumes the rate is given in fine units per tick.
`timescale 1ns/1ps
`default_nettype none
`include "vtc_defines.svh"
module vtc_slew
    import vtc_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Target and rate.
    input wire logic tick,
    input wire logic signed [23:0] target,
    input wire logic [15:0] rate,
    // Reference out.
    output logic signed [23:0] ref_out,
    output logic settled
);
    typedef struct packed {
        logic signed [23:0] ref_v;
    } vtc_slew_st_t;
    vtc_slew_st_t s_q, s_d;
    logic signed [24:0] diff;
    logic signed [24:0] step;
    always_comb begin
        s_d = s_q;
        // The rate is unsigned; comparing it unsigned against a falling
        // difference would send the reference the wrong way.
        step = $signed({9'h0, rate});
        diff = 25'(target) - 25'(s_q.ref_v);
        if (tick) begin
            if (diff > step)
                s_d.ref_v = s_q.ref_v + 24'(rate);
            else if (diff < -step)
                s_d.ref_v = s_q.ref_v - 24'(rate);
            else
                s_d.ref_v = target;
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end
    assign ref_out = s_q.ref_v;
    assign settled = (diff == 25'h0);
endmodule
`default_nettype wire

// *** verilog/vtc_target.sv ***
// Output-voltage format, target and offset registers of one output rail,
// with boot-value selection, limit clamping and a slewed reference.
// Assumes a link layer that presents decoded byte and word commands.
`timescale 1ns/1ps
`default_nettype none
`include "vtc_defines.svh"
module vtc_target
    import vtc_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Decoded command port from the link layer.
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    output logic cmd_rvalid,
    // Limits and rate in fine units (exponent -12).
    input wire logic [23:0] limit_max,
    input wire logic [23:0] limit_min,
    input wire logic [1:0] loop_scale_sel,
    input wire logic [15:0] transition_rate,
    // Conversion state and boot sources.
    input wire logic conversion_enabled,
    input wire logic restore_user_all,
    input wire logic default_source_select,
    input wire logic [15:0] voltage_select_pin,
    input wire logic [15:0] nv_target,
    input wire logic [7:0] nv_offset,
    input wire logic [7:0] nv_format,
    // Option bits and events.
    input wire logic reset_pin_mode,
    input wire logic power_good_or_reset_pin,
    input wire logic fault_restore_default_bit,
    input wire logic fault_shutdown,
    // Results.
    output logic [23:0] reference_level,
    output logic reference_settled,
    output logic [7:0] nv_offset_backup,
    output logic voltage_limit_warning,
    output logic invalid_data,
    output logic host_alert
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic relative_format_flag;
        logic [4:0] expn;
        logic [15:0] target;
        logic [15:0] offset;
        logic [23:0] boot_fine;
        vtc_state_t st;
        logic [4:0] new_exp;
        logic new_rel;
        logic signed [23:0] goal;
        logic warn;
        logic inval;
        logic [15:0] rdata;
        logic rvalid;
        logic [15:0] tick_cnt;
        logic booted;
        logic over;
    } vtc_st_t;
    vtc_st_t s_q, s_d;

    function automatic logic exp_ok(input logic [4:0] e);
        logic signed [4:0] se;
        se = $signed(e);
        exp_ok = (se >= 5'(`VTC_EXP_MIN)) && (se <= 5'(`VTC_EXP_MAX));
    endfunction

    // Hardware maximum of the reference, fine units, by loop scale.
    function automatic logic signed [23:0] hw_max(input logic [1:0] sel);
        unique case (sel)
            2'h0: hw_max = 24'sd2867;
            2'h1: hw_max = 24'sd5734;
            2'h2: hw_max = 24'sd11468;
            2'h3: hw_max = 24'sd24576;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Scaling of target and offset into fine units
    // ------------------------------------------------------------------
    logic signed [23:0] tgt_fine, off_fine, tgt_wfine, off_wfine;
    logic signed [16:0] boot_mant;
    logic [4:0] conv_exp;
    assign conv_exp = (s_q.st == VTC_CONVERT) ? s_q.new_exp : s_q.expn;

    vtc_scale u_tgt (
        .mant_in({1'b0, s_q.target}),
        .exp_in(s_q.expn),
        .fine_out(tgt_fine),
        .fine_in(24'sd0),
        .mant_out()
    );
    vtc_scale u_off (
        .mant_in({s_q.offset[15], s_q.offset}),
        .exp_in(s_q.expn),
        .fine_out(off_fine),
        .fine_in(24'sd0),
        .mant_out()
    );
    vtc_scale u_wt (
        .mant_in({1'b0, cmd_wdata}),
        .exp_in(s_q.expn),
        .fine_out(tgt_wfine),
        .fine_in(s_q.boot_fine),
        .mant_out(boot_mant)
    );
    vtc_scale u_wo (
        .mant_in({cmd_wdata[15], cmd_wdata}),
        .exp_in(s_q.expn),
        .fine_out(off_wfine),
        .fine_in(24'sd0),
        .mant_out()
    );
    // Reconversion at the new exponent uses a third scaler pair.
    logic signed [16:0] tgt_new, off_new;
    vtc_scale u_nt (
        .mant_in(17'sd0),
        .exp_in(conv_exp),
        .fine_out(),
        .fine_in(tgt_fine),
        .mant_out(tgt_new)
    );
    vtc_scale u_no (
        .mant_in(17'sd0),
        .exp_in(conv_exp),
        .fine_out(),
        .fine_in(off_fine),
        .mant_out(off_new)
    );

    // Boot source: pin detection or stored value, both at own exponent.
    logic [15:0] boot_src;
    assign boot_src = default_source_select ? voltage_select_pin
                                            : nv_target;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic signed [24:0] sum;
    logic signed [24:0] sum_w;
    logic signed [23:0] goal_v;
    logic limit_hit;
    logic tick;
    logic signed [7:0] trim_nv;
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        tick = (s_q.tick_cnt == 16'(`VTC_STEP_CYCLES - 1));
        s_d.tick_cnt = tick ? 16'h0 : s_q.tick_cnt + 16'h1;
        sum_w = 25'sd0;
        limit_hit = 1'b0;
        goal_v = s_q.goal;
        // Status clears come first, so that an event in the same cycle wins.
        if (cmd_rd && cmd_code == `VTC_CMD_TARGET)
            s_d.warn = 1'b0;
        if (cmd_rd && cmd_code == `VTC_CMD_OFFSET)
            s_d.inval = 1'b0;

        // First cycle after reset: capture the boot default.
        if (!s_q.booted || restore_user_all) begin
            s_d.booted = 1'b1;
            s_d.relative_format_flag = nv_format[`VTC_REL_BIT];
            s_d.expn = exp_ok(nv_format[`VTC_EXP_HI:`VTC_EXP_LO]) ?
                nv_format[`VTC_EXP_HI:`VTC_EXP_LO] : `VTC_EXP_RESET;
            s_d.target = boot_src;
            // Backup is held at exponent -12 by construction.
            s_d.boot_fine = {8'h0, boot_src};
            s_d.offset = {{8{nv_offset[7]}}, nv_offset};
            s_d.st = VTC_IDLE;
        end else if (reset_pin_mode && !power_good_or_reset_pin) begin
            s_d.target = 16'(boot_mant);
        end else if (fault_shutdown && fault_restore_default_bit) begin
            s_d.target = boot_src;
        end else begin
            unique case (s_q.st)
                VTC_IDLE: begin
                    if (cmd_wr && cmd_code == `VTC_CMD_FORMAT) begin
                        if (conversion_enabled) begin
                            s_d.inval = 1'b1;
                        end else if (cmd_wdata[`VTC_MODE_HI:`VTC_MODE_LO]
                                     != `VTC_MODE_LINEAR ||
                                     !exp_ok(cmd_wdata[4:0])) begin
                            s_d.inval = 1'b1;
                        end else begin
                            s_d.new_rel = cmd_wdata[`VTC_REL_BIT];
                            s_d.new_exp = cmd_wdata[4:0];
                            s_d.st = VTC_CONVERT;
                        end
                    end else if (cmd_wr && cmd_code == `VTC_CMD_TARGET) begin
                        s_d.target = cmd_wdata;
                    end else if (cmd_wr && cmd_code == `VTC_CMD_OFFSET) begin
                        sum_w = 25'(tgt_fine) + 25'(off_wfine);
                        if (sum_w < 25'sd0 ||
                            sum_w > 25'(hw_max(2'h3))) begin
                            s_d.inval = 1'b1;
                        end else begin
                            s_d.offset = cmd_wdata;
                        end
                    end
                end
                VTC_CONVERT: begin
                    // Target and offset are re-expressed at the new exponent.
                    s_d.target = 16'(tgt_new);
                    s_d.offset = 16'(off_new);
                    s_d.expn = s_q.new_exp;
                    s_d.relative_format_flag = s_q.new_rel;
                    s_d.st = VTC_IDLE;
                end
                default: s_d.st = VTC_IDLE;
            endcase
        end

        // Reference goal: command plus offset, clamped.
        sum = 25'(tgt_fine) + 25'(off_fine);
        if (sum > $signed({1'b0, limit_max})) begin
            goal_v = 24'(limit_max);
            limit_hit = 1'b1;
        end else if (sum < $signed({1'b0, limit_min})) begin
            goal_v = 24'(limit_min);
            limit_hit = 1'b1;
        end else if (sum > 25'(hw_max(loop_scale_sel))) begin
            goal_v = hw_max(loop_scale_sel);
        end else begin
            goal_v = 24'(sum);
        end
        if (goal_v > hw_max(loop_scale_sel))
            goal_v = hw_max(loop_scale_sel);
        s_d.goal = goal_v;
        s_d.over = limit_hit;
        // The warning is an event: it rises when the sum leaves the limits,
        // so a read can clear it while the clamp still holds.
        if (limit_hit && !s_q.over)
            s_d.warn = 1'b1;

        // Reads return the registers; the warning is cleared on a target read and
        // the invalid flag on an offset read, but a new event in the same cycle wins.
        if (cmd_rd) begin
            s_d.rvalid = 1'b1;
            unique case (cmd_code)
                `VTC_CMD_FORMAT: s_d.rdata = {8'h0, s_q.relative_format_flag,
                    `VTC_MODE_LINEAR, s_q.expn};
                `VTC_CMD_TARGET: s_d.rdata = s_q.target;
                `VTC_CMD_OFFSET: s_d.rdata = s_q.offset;
                default: s_d.rdata = 16'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.expn <= `VTC_EXP_RESET;
            s_q.st <= VTC_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Slewed reference and outputs
    // ------------------------------------------------------------------
    logic signed [23:0] ref_v;
    vtc_slew u_slew (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .tick(s_q.tick_cnt == 16'h0),
        .target(s_q.goal),
        .rate(transition_rate),
        .ref_out(ref_v),
        .settled(reference_settled)
    );

    // Backup of the offset saturates to one signed byte at -12.
    always_comb begin
        if (off_fine > 24'sd`VTC_NV_TRIM_MAX)
            trim_nv = 8'sd127;
        else if (off_fine < -24'sd128)
            trim_nv = -8'sd128;
        else
            trim_nv = 8'(off_fine);
    end

    assign reference_level = ref_v;
    assign nv_offset_backup = trim_nv;
    assign voltage_limit_warning = s_q.warn;
    assign invalid_data = s_q.inval;
    assign host_alert = s_q.warn | s_q.inval;
    assign cmd_rdata = s_q.rdata;
    assign cmd_rvalid = s_q.rvalid;
endmodule
`default_nettype wire
